// [hdl/nmi_trap_defs.svh]
`ifndef NMI_TRAP_DEFS_SVH
`define NMI_TRAP_DEFS_SVH

// register width and register selector codes
`define XLEN 64
`define SEL_SCRATCH 2'h0
`define SEL_SAVED_PC 2'h1
`define SEL_CAUSE 2'h2
`define SEL_STATUS 2'h3

// status field positions
`define ST_PRIV_HI 12
`define ST_PRIV_LO 11
`define ST_LPAD 9
`define ST_VIRT 7
`define ST_ENABLE 3

// reset values
`define NMI_ENABLE_RESET 1'h0
`define PRIV_MACHINE 2'h3

// default vectors, arbitrary
`define NMI_VECTOR_DEFAULT 64'h0000_0000_0000_1000
`define NMI_EXC_VECTOR_DEFAULT 64'h0000_0000_0000_1100

`endif

// [hdl/nmi_trap_pkg.sv]
package nmi_trap_pkg;
    typedef struct packed {
        logic [63:0] pc;
        logic [1:0] priv;
        logic virt;
        logic lpad;
    } hart_ctx_t;

    typedef struct packed {
        logic en;
        logic we;
        logic [1:0] sel;
        logic [63:0] wdata;
    } csr_req_t;
endpackage

// [hdl/nmi_status_reg.sv]
`include "nmi_trap_defs.svh"

// status register: enable is set-only from software, cleared by trap entry
module nmi_status_reg
    import nmi_trap_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic sw_write,
    input wire logic [63:0] sw_wdata,
    input wire logic trap_take,
    input wire hart_ctx_t trap_ctx,
    input wire logic ret_take,
    // state
    output logic [63:0] status_rd,
    output logic nmi_enable
);
    logic enable_reg;
    logic [1:0] priv_reg;
    logic virt_reg;
    logic lpad_reg;
    logic enable_next;

    // trap clears, return or software one sets; software zero is ignored
    assign enable_next = trap_take ? 1'h0 :
        ((ret_take || (sw_write && sw_wdata[`ST_ENABLE])) ? 1'h1 : enable_reg);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enable_reg <= `NMI_ENABLE_RESET;
            priv_reg <= `PRIV_MACHINE;
            virt_reg <= 1'h0;
            lpad_reg <= 1'h0;
        end else begin
            enable_reg <= enable_next;
            if (trap_take) begin
                priv_reg <= trap_ctx.priv;
                virt_reg <= trap_ctx.virt;
                lpad_reg <= trap_ctx.lpad;
            end else if (sw_write) begin
                priv_reg <= sw_wdata[`ST_PRIV_HI:`ST_PRIV_LO];
                virt_reg <= sw_wdata[`ST_VIRT];
                lpad_reg <= sw_wdata[`ST_LPAD];
            end
        end
    end

    // reserved bits read as zero
    always_comb begin
        status_rd = 64'h0;
        status_rd[`ST_PRIV_HI:`ST_PRIV_LO] = priv_reg;
        status_rd[`ST_VIRT] = virt_reg;
        status_rd[`ST_LPAD] = lpad_reg;
        status_rd[`ST_ENABLE] = enable_reg;
    end
    assign nmi_enable = enable_reg;

    p_sw_zero_keeps: assert property (@(posedge mclk) disable iff (rst)
        (sw_write && !sw_wdata[`ST_ENABLE] && !trap_take && enable_reg) |=> enable_reg)
        else $error("software zero cleared enable");
endmodule // nmi_status_reg

// [hdl/resumable_nmi_trap_state.sv]
`include "nmi_trap_defs.svh"
module resumable_nmi_trap_state
    import nmi_trap_pkg::*;
#(
    parameter logic [63:0] NMI_VECTOR = `NMI_VECTOR_DEFAULT,
    parameter logic [63:0] NMI_EXC_VECTOR = `NMI_EXC_VECTOR_DEFAULT,
    parameter logic ALIGN_SWITCHABLE = 1'h1
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // platform interrupt inputs
    input wire logic resumable_nmi,
    input wire logic [62:0] nmi_cause_code,
    // hart context
    input wire logic insn_boundary,
    input wire hart_ctx_t cur_ctx,
    input wire logic align32,
    input wire logic machine_interrupt_enable,
    input wire logic modify_privilege_flag,
    input wire logic other_irq_pending,
    input wire logic wfi_irq_pending,
    // exceptions
    input wire logic exc_valid,
    input wire logic exc_double_trap,
    input wire logic [62:0] exc_code,
    // return instruction
    input wire logic resumable_return,
    // register access port
    input wire csr_req_t csr_req,
    output logic [63:0] csr_rdata,
    // control outputs
    output logic nmi_take,
    output logic redirect_valid,
    output logic [63:0] redirect_pc,
    output logic [1:0] new_priv,
    output logic new_virt,
    output logic clear_landing_pad,
    output logic clear_modify_privilege,
    output logic squash_retire,
    output logic effective_modify_privilege_flag,
    output logic other_irq_allowed,
    output logic wfi_wake,
    output logic nmi_enable
);
    logic [63:0] scratch_reg;
    logic [63:0] saved_pc_reg;
    logic [63:0] cause_reg;
    logic [63:0] status_rd;
    logic [63:0] pc_rd;
    logic double_take;
    logic masked_exc;
    logic ret_go;
    logic sw_wr;

    function automatic logic [63:0] pc_mask(input logic [63:0] v, input logic a32);
        pc_mask = {v[63:2], v[1] & ~a32, 1'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // take decisions; nmi is checked before any other trap source
    assign nmi_take = resumable_nmi && nmi_enable && insn_boundary;
    assign masked_exc = exc_valid && !nmi_enable && !nmi_take;
    assign double_take = masked_exc && exc_double_trap;
    assign ret_go = resumable_return && !nmi_take;
    assign sw_wr = csr_req.en && csr_req.we;
    assign squash_retire = nmi_take;
    // no other interrupt while enable is zero, machine enable aside
    assign other_irq_allowed = other_irq_pending && nmi_enable && !nmi_take;
    // wake ignores enable entirely
    assign wfi_wake = wfi_irq_pending || resumable_nmi;
    assign effective_modify_privilege_flag = modify_privilege_flag && nmi_enable;

    ////////////////////////////////////////////////////////////////////////
    // redirect and mode change
    assign redirect_valid = nmi_take || masked_exc || ret_go;
    assign redirect_pc = nmi_take ? NMI_VECTOR :
        (masked_exc ? NMI_EXC_VECTOR : pc_rd);
    assign new_priv = ret_go ? status_rd[`ST_PRIV_HI:`ST_PRIV_LO] : `PRIV_MACHINE;
    assign new_virt = ret_go ? status_rd[`ST_VIRT] : 1'h0;
    assign clear_landing_pad = nmi_take;
    assign clear_modify_privilege = ret_go &&
        (status_rd[`ST_PRIV_HI:`ST_PRIV_LO] != `PRIV_MACHINE);

    ////////////////////////////////////////////////////////////////////////
    // context registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scratch_reg <= 64'h0;
            saved_pc_reg <= 64'h0;
            cause_reg <= 64'h0;
        end else begin
            if (sw_wr && csr_req.sel == `SEL_SCRATCH) begin
                scratch_reg <= csr_req.wdata;
            end
            if (nmi_take) begin
                saved_pc_reg <= {cur_ctx.pc[63:1], 1'h0};
            end else if (sw_wr && csr_req.sel == `SEL_SAVED_PC) begin
                saved_pc_reg <= {csr_req.wdata[63:1], 1'h0};
            end
            if (nmi_take) begin
                cause_reg <= {1'h1, nmi_cause_code};
            end else if (double_take) begin
                cause_reg <= {1'h0, exc_code};
            end else if (sw_wr && csr_req.sel == `SEL_CAUSE) begin
                cause_reg <= csr_req.wdata;
            end
        end
    end

    // bit one hides under 32-bit alignment, still stored
    assign pc_rd = pc_mask(saved_pc_reg, align32 || !ALIGN_SWITCHABLE);

    nmi_status_reg u_status (
        .mclk(mclk),
        .rst(rst),
        .sw_write(sw_wr && csr_req.sel == `SEL_STATUS),
        .sw_wdata(csr_req.wdata),
        .trap_take(nmi_take),
        .trap_ctx(cur_ctx),
        .ret_take(ret_go),
        .status_rd(status_rd),
        .nmi_enable(nmi_enable)
    );

    // read mux
    always_comb begin
        unique case (csr_req.sel)
            `SEL_SCRATCH: csr_rdata = scratch_reg;
            `SEL_SAVED_PC: csr_rdata = pc_rd;
            `SEL_CAUSE: csr_rdata = cause_reg;
            `SEL_STATUS: csr_rdata = status_rd;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    p_pc_saved: assert property (@(posedge mclk) disable iff (rst)
        nmi_take |=> saved_pc_reg[63:1] == $past(cur_ctx.pc[63:1]))
        else $error("saved pc wrong");
    p_bit0: assert property (@(posedge mclk) disable iff (rst)
        pc_rd[0] == 1'h0) else $error("pc bit zero set");
    p_cause_irq: assert property (@(posedge mclk) disable iff (rst)
        nmi_take |=> cause_reg[63] && cause_reg[62:0] == $past(nmi_cause_code))
        else $error("interrupt cause wrong");
    p_cause_dbl: assert property (@(posedge mclk) disable iff (rst)
        double_take |=> !cause_reg[63]) else $error("double trap cause wrong");
    p_priv: assert property (@(posedge mclk) disable iff (rst)
        nmi_take |=> status_rd[12:11] == $past(cur_ctx.priv)) else $error("priv not saved");
    p_clear_en: assert property (@(posedge mclk) disable iff (rst)
        nmi_take |=> !nmi_enable) else $error("enable not cleared");
    p_ret_set: assert property (@(posedge mclk) disable iff (rst)
        ret_go |=> nmi_enable) else $error("return did not set enable");
    p_masked: assert property (@(posedge mclk) disable iff (rst)
        !nmi_enable |-> !nmi_take && !other_irq_allowed) else $error("irq while masked");
    p_modify_privilege_flag: assert property (@(posedge mclk) disable iff (rst)
        !nmi_enable |-> !effective_modify_privilege_flag) else $error("modify_privilege_flag leaked");
    p_vec: assert property (@(posedge mclk) disable iff (rst)
        masked_exc |-> redirect_pc == NMI_EXC_VECTOR) else $error("wrong exception vector");
endmodule // resumable_nmi_trap_state

// [verification/nmi_source.sv]
// platform side: raises the resumable interrupt as a level with its cause code
module nmi_source (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bench control
    input wire logic fire,
    input wire logic [62:0] code,
    // lines toward the hart
    output logic resumable_nmi,
    output logic [62:0] nmi_cause_code
);
    logic [62:0] last_reg;
    // keep the last code so an idle line shows its inverse, never a stale value
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_reg <= 63'h0;
        end else if (fire) begin
            last_reg <= code;
        end
    end
    // request is held for as long as the source wants service
    assign resumable_nmi = fire;
    assign nmi_cause_code = fire ? code : ~last_reg;
endmodule // nmi_source

// [verification/resumable_nmi_trap_state_test.sv]
`include "nmi_trap_defs.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module resumable_nmi_trap_state_test
    import nmi_trap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] sel; logic [63:0] wd; logic [63:0] rd;} row_t;
    logic mclk = 0, rst = 1, fire = 0, insn_boundary = 1, align32 = 0, exc_valid = 0;
    logic machine_interrupt_enable = 0, modify_privilege_flag = 1, other_irq_pending = 1;
    logic wfi_irq_pending = 0, exc_double_trap = 0, resumable_return = 0;
    logic [62:0] code = 63'h7, exc_code = 63'h5, nmi_cause_code;
    hart_ctx_t cur_ctx = '{64'h0000_0000_8000_1234, 2'h1, 1'h1, 1'h1};
    csr_req_t csr_req = '0;
    logic resumable_nmi, nmi_take, redirect_valid, new_virt, clear_landing_pad, nmi_enable;
    logic clear_modify_privilege, squash_retire, effective_modify_privilege_flag, other_irq_allowed, wfi_wake;
    logic [63:0] csr_rdata, redirect_pc;
    logic [1:0] new_priv;
    int errors = 0, total_checks = 0;
    // ordinary register traffic: write, then read back through the same selector
    row_t rows [5] = '{
        '{`SEL_SCRATCH, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF},
        '{`SEL_SCRATCH, 64'h0123_4567_89AB_CDEF, 64'h0123_4567_89AB_CDEF},
        '{`SEL_SAVED_PC, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFE},
        '{`SEL_CAUSE, 64'h8000_0000_0000_0005, 64'h8000_0000_0000_0005},
        '{`SEL_STATUS, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0000_0000_0000_1A88}};
    nmi_source i_src (.mclk, .rst, .fire, .code, .resumable_nmi, .nmi_cause_code);
    resumable_nmi_trap_state i_dut (.mclk, .rst, .resumable_nmi, .nmi_cause_code,
        .insn_boundary, .cur_ctx, .align32, .machine_interrupt_enable, .modify_privilege_flag,
        .other_irq_pending, .wfi_irq_pending, .exc_valid, .exc_double_trap, .exc_code,
        .resumable_return, .csr_req, .csr_rdata, .nmi_take, .redirect_valid, .redirect_pc,
        .new_priv, .new_virt, .clear_landing_pad, .clear_modify_privilege, .squash_retire,
        .effective_modify_privilege_flag, .other_irq_allowed, .wfi_wake, .nmi_enable);
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    task step();
        @(posedge mclk);
        #1;
    endtask
    // one write cycle; enable drops after the taking edge
    task csr_wr(input logic [1:0] s, input logic [63:0] d);
        csr_req = '{1'b1, 1'b1, s, d};
        step();
        csr_req.en = 1'b0;
    endtask
    // reads are combinational, so settle one nanosecond before looking
    task rd(input logic [1:0] s);
        csr_req.sel = s;
        #1;
    endtask
    task end_sim();
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the fifteen or so cycles the sequence needs
    initial begin
        #20000;
        errors++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge mclk);
        #1 rst = 0;
        fire = 1;
        rd(`SEL_STATUS);
        `CHK("status_reset", 64'h0000_0000_0000_1800, csr_rdata)
        `CHK("masked_take", 1'b0, nmi_take)
        `CHK("masked_other", 1'b0, other_irq_allowed)
        `CHK("modify_privilege_flag_off", 1'b0, effective_modify_privilege_flag)
        `CHK("wfi_wake", 1'b1, wfi_wake)
        step();
        fire = 0;
        foreach (rows[i]) begin
            csr_wr(rows[i].sel, rows[i].wd);
            rd(rows[i].sel);
            `CHK("row_read", rows[i].rd, csr_rdata)
        end
        align32 = 1;
        rd(`SEL_SAVED_PC);
        `CHK("pc_bit1_masked", 64'hFFFF_FFFF_FFFF_FFFC, csr_rdata)
        align32 = 0;
        rd(`SEL_SAVED_PC);
        `CHK("pc_bit1_kept", 64'hFFFF_FFFF_FFFF_FFFE, csr_rdata)
        step();
        csr_wr(`SEL_STATUS, 64'h0);
        `CHK("enable_kept", 1'b1, nmi_enable)
        // interrupt off a boundary must wait; then it beats a same-cycle exception
        fire = 1;
        insn_boundary = 0;
        #1 `CHK("no_boundary", 1'b0, nmi_take)
        `CHK("no_redirect", 1'b0, redirect_valid)
        `CHK("enabled_other", 1'b1, other_irq_allowed)
        `CHK("modify_privilege_flag_passes", 1'b1, effective_modify_privilege_flag)
        insn_boundary = 1;
        exc_valid = 1;
        #1 `CHK("take", 1'b1, nmi_take)
        `CHK("vector", 64'h0000_0000_0000_1000, redirect_pc)
        `CHK("to_machine", 2'h3, new_priv)
        `CHK("lpad_clear", 1'b1, clear_landing_pad)
        `CHK("squash", 1'b1, squash_retire)
        `CHK("take_redirect", 1'b1, redirect_valid)
        `CHK("take_other_off", 1'b0, other_irq_allowed)
        step();
        fire = 0;
        rd(`SEL_SAVED_PC);
        `CHK("saved_pc", 64'h0000_0000_8000_1234, csr_rdata)
        rd(`SEL_CAUSE);
        `CHK("cause", 64'h8000_0000_0000_0007, csr_rdata)
        rd(`SEL_STATUS);
        `CHK("status_ctx", 64'h0000_0000_0000_0A80, csr_rdata)
        `CHK("enable_off", 1'b0, nmi_enable)
        // double trap while masked goes to the second vector and records the code
        exc_double_trap = 1;
        #1 `CHK("exc_vector", 64'h0000_0000_0000_1100, redirect_pc)
        step();
        exc_valid = 0;
        exc_double_trap = 0;
        rd(`SEL_CAUSE);
        `CHK("dbl_cause", 64'h0000_0000_0000_0005, csr_rdata)
        resumable_return = 1;
        #1 `CHK("ret_pc", 64'h0000_0000_8000_1234, redirect_pc)
        `CHK("ret_priv", 2'h1, new_priv)
        `CHK("ret_virt", 1'b1, new_virt)
        `CHK("ret_modify_privilege_flag", 1'b1, clear_modify_privilege)
        step();
        resumable_return = 0;
        `CHK("ret_enable", 1'b1, nmi_enable)
        // second reset in mid-run: enable must drop and privilege return to machine
        rst = 1;
        step();
        rst = 0;
        rd(`SEL_STATUS);
        `CHK("status_rereset", 64'h0000_0000_0000_1800, csr_rdata)
        `CHK("enable_rereset", 1'b0, nmi_enable)
        end_sim();
    end
endmodule // resumable_nmi_trap_state_test
